// ===== srxp_pkg.sv
/*
  shared constants and carriers for the serial receive phy control registers.
  assumes 12-bit register addresses and 8-bit register data from the control port.
*/
package srxp_pkg;

  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 8;
  localparam int NUM_LANES = 8;
  localparam int EQ_W      = 4;

  // register offsets
  localparam logic [11:0] ADDR_RX_MASTER_POWERDOWN  = 12'h200;
  localparam logic [11:0] ADDR_LANE_PD    = 12'h201;
  localparam logic [11:0] ADDR_AUX_PD     = 12'h203;
  localparam logic [11:0] ADDR_RECOV_RST  = 12'h206;
  localparam logic [11:0] ADDR_RECOV_MODE = 12'h230;
  localparam logic [11:0] ADDR_EQ_01      = 12'h250;

  // reset values
  localparam logic [7:0] RST_RX_MASTER_POWERDOWN  = 8'h01;
  localparam logic [7:0] RST_LANE_PD    = 8'h00;
  localparam logic [7:0] RST_AUX_PD     = 8'h00;
  localparam logic [7:0] RST_RECOV_RST  = 8'h01;
  localparam logic [7:0] RST_RECOV_MODE = 8'h28;
  localparam logic [7:0] RST_EQ_01      = 8'h88;
  localparam logic [3:0] RST_EQ_FIELD   = 4'h8;

  // writable bits; all others are read-only zero
  localparam logic [7:0] MASK_RX_MASTER_POWERDOWN  = 8'h01;
  localparam logic [7:0] MASK_AUX_PD     = 8'h03;
  localparam logic [7:0] MASK_RECOV_RST  = 8'h01;

  // field positions
  localparam int BIT_ALL_PD    = 0;
  localparam int BIT_SYNC_PD   = 1;
  localparam int BIT_RECOV_RST = 0;
  localparam int BIT_HALF_RATE = 5;
  localparam int DIV_LSB       = 1;
  localparam int EQ_L0_LSB     = 0;
  localparam int EQ_L1_LSB     = 4;

  // oversampling division codes and the equalizer manual code
  localparam logic [1:0] DIV_CODE_NONE = 2'h0;
  localparam logic [1:0] DIV_CODE_BY2  = 2'h1;
  localparam logic [1:0] DIV_CODE_BY4  = 2'h2;
  localparam logic [3:0] EQ_MANUAL     = 4'h0;

  typedef enum logic [2:0] {
    DIV_SEL_NONE = 3'h1,
    DIV_SEL_BY2  = 3'h2,
    DIV_SEL_BY4  = 3'h4
  } srxp_div_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } srxp_req_s;

  typedef struct packed {
    logic       manual;
    logic [3:0] boost;
  } srxp_eq_s;

endpackage

// ===== srxp_eq_lane.sv
/*
  one lane's equalizer decode, registered.
  assumes the field's next value comes from the owning register's next value.
*/
`timescale 1ns/10ps
module srxp_eq_lane
  import srxp_pkg::*;
#(
  parameter logic [3:0] RST_FIELD = 4'h8
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [3:0] field_nxt_i,
  output srxp_eq_s        eq_o
);

  srxp_eq_s eq_r;
  srxp_eq_s eq_nxt;

  always_comb begin
    eq_nxt = eq_r;
    if (ce_i) begin
      eq_nxt.manual = (field_nxt_i == EQ_MANUAL);
      eq_nxt.boost  = field_nxt_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      eq_r <= '{manual: (RST_FIELD == EQ_MANUAL), boost: RST_FIELD};
    end else begin
      eq_r <= eq_nxt;
    end
  end

  assign eq_o = eq_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  manual_zero_boost_a: assert property (eq_r.manual == (eq_r.boost == EQ_MANUAL))
    else $error("manual flag disagrees with boost field");
  boost_follows_a: assert property (ce_i |=> eq_r.boost == $past(field_nxt_i))
    else $error("boost level did not follow field");

endmodule

// ===== srxp_regs.sv
/*
  serial receive phy control register bank: power-down, recovery reset,
  recovery mode and lane 0/1 equalizer registers with registered controls.
  assumes one access request per cycle on the control port side, synchronous
  to mclk_i, and analog lane circuits that act on the control outputs.
*/
`timescale 1ns/10ps
module srxp_regs
  import srxp_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  srxp_req_s       req_i,
  output logic [7:0]      rdata_o,
  output logic            rvalid_o,
  output logic            rx_all_powerdown_o,
  output logic [7:0]      lane_powerdown_bits_o,
  output logic [7:0]      lane_rx_powerdown_o,
  output logic            sync_buffer_powerdown_o,
  output logic            recovery_logic_reset_o,
  output logic            recovery_half_rate_enable_o,
  output srxp_div_e       div_sel_o,
  output srxp_eq_s        lane0_equalizer_o,
  output srxp_eq_s        lane1_equalizer_o
);

  logic [7:0] master_r;
  logic [7:0] master_nxt;
  logic [7:0] lane_r;
  logic [7:0] lane_nxt;
  logic [7:0] aux_r;
  logic [7:0] aux_nxt;
  logic [7:0] recov_rst_r;
  logic [7:0] recov_rst_nxt;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] eq01_r;
  logic [7:0] eq01_nxt;

  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;
  logic [7:0] lane_eff_r;
  logic [7:0] lane_eff_nxt;
  srxp_div_e  div_r;
  srxp_div_e  div_nxt;

  logic       wr_en;
  logic       rd_en;

  assign wr_en = ce_i & req_i.wr;
  assign rd_en = ce_i & req_i.rd;

  // register writes; read-only bits are masked so they stay zero
  always_comb begin
    master_nxt    = master_r;
    lane_nxt      = lane_r;
    aux_nxt       = aux_r;
    recov_rst_nxt = recov_rst_r;
    mode_nxt      = mode_r;
    eq01_nxt      = eq01_r;
    if (wr_en) begin
      case (req_i.addr)
        ADDR_RX_MASTER_POWERDOWN: begin
          master_nxt = req_i.wdata & MASK_RX_MASTER_POWERDOWN;
        end
        ADDR_LANE_PD: begin
          lane_nxt = req_i.wdata;
        end
        ADDR_AUX_PD: begin
          aux_nxt = req_i.wdata & MASK_AUX_PD;
        end
        ADDR_RECOV_RST: begin
          recov_rst_nxt = req_i.wdata & MASK_RECOV_RST;
        end
        ADDR_RECOV_MODE: begin
          mode_nxt = req_i.wdata;
        end
        ADDR_EQ_01: begin
          eq01_nxt = req_i.wdata;
        end
        default: begin
          master_nxt = master_r;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      master_r    <= RST_RX_MASTER_POWERDOWN;
      lane_r      <= RST_LANE_PD;
      aux_r       <= RST_AUX_PD;
      recov_rst_r <= RST_RECOV_RST;
      mode_r      <= RST_RECOV_MODE;
      eq01_r      <= RST_EQ_01;
    end else begin
      master_r    <= master_nxt;
      lane_r      <= lane_nxt;
      aux_r       <= aux_nxt;
      recov_rst_r <= recov_rst_nxt;
      mode_r      <= mode_nxt;
      eq01_r      <= eq01_nxt;
    end
  end

  // read port; unmapped addresses read zero
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    if (!ce_i) begin
      rvalid_nxt = rvalid_r;
    end else if (rd_en) begin
      rvalid_nxt = 1'b1;
      case (req_i.addr)
        ADDR_RX_MASTER_POWERDOWN: begin
          rdata_nxt = master_r;
        end
        ADDR_LANE_PD: begin
          rdata_nxt = lane_r;
        end
        ADDR_AUX_PD: begin
          rdata_nxt = aux_r;
        end
        ADDR_RECOV_RST: begin
          rdata_nxt = recov_rst_r;
        end
        ADDR_RECOV_MODE: begin
          rdata_nxt = mode_r;
        end
        ADDR_EQ_01: begin
          rdata_nxt = eq01_r;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // derived controls built from next values so they never lag the registers
  always_comb begin
    lane_eff_nxt = {NUM_LANES{master_nxt[BIT_ALL_PD]}} | lane_nxt;
    case (mode_nxt[DIV_LSB +: 2])
      DIV_CODE_NONE: begin
        div_nxt = DIV_SEL_NONE;
      end
      DIV_CODE_BY2: begin
        div_nxt = DIV_SEL_BY2;
      end
      DIV_CODE_BY4: begin
        div_nxt = DIV_SEL_BY4;
      end
      default: begin
        // undefined code: slowest division is the safe fallback
        div_nxt = DIV_SEL_BY4;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lane_eff_r <= {NUM_LANES{RST_RX_MASTER_POWERDOWN[BIT_ALL_PD]}} | RST_LANE_PD;
      div_r      <= DIV_SEL_NONE;
    end else begin
      lane_eff_r <= lane_eff_nxt;
      div_r      <= div_nxt;
    end
  end

  srxp_eq_lane #(
    .RST_FIELD (RST_EQ_FIELD)
  ) u_eq_lane0 (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .field_nxt_i (eq01_nxt[EQ_L0_LSB +: EQ_W]),
    .eq_o        (lane0_equalizer_o)
  );

  srxp_eq_lane #(
    .RST_FIELD (RST_EQ_FIELD)
  ) u_eq_lane1 (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .field_nxt_i (eq01_nxt[EQ_L1_LSB +: EQ_W]),
    .eq_o        (lane1_equalizer_o)
  );

  assign rdata_o                     = rdata_r;
  assign rvalid_o                    = rvalid_r;
  assign rx_all_powerdown_o          = master_r[BIT_ALL_PD];
  assign lane_powerdown_bits_o       = lane_r;
  assign lane_rx_powerdown_o         = lane_eff_r;
  assign sync_buffer_powerdown_o     = aux_r[BIT_SYNC_PD];
  assign recovery_logic_reset_o      = recov_rst_r[BIT_RECOV_RST];
  assign recovery_half_rate_enable_o = mode_r[BIT_HALF_RATE];
  assign div_sel_o                   = div_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  rx_master_powerdown_write_a: assert property (
    wr_en && req_i.addr == ADDR_RX_MASTER_POWERDOWN |=> rx_all_powerdown_o == $past(req_i.wdata[0])
  ) else $error("master power-down did not take written bit");

  lane_pd_combine_a: assert property (
    lane_rx_powerdown_o == ({NUM_LANES{rx_all_powerdown_o}} | lane_powerdown_bits_o)
  ) else $error("lane power-down not master or lane bit");

  sync_pd_write_a: assert property (
    wr_en && req_i.addr == ADDR_AUX_PD |=> sync_buffer_powerdown_o == $past(req_i.wdata[1])
  ) else $error("sync buffer power-down did not take written bit");

  recov_reset_out_a: assert property (
    $fell(rst_i) |-> recovery_logic_reset_o && rx_all_powerdown_o
  ) else $error("recovery reset or master power-down not set after reset");

  half_rate_write_a: assert property (
    wr_en && req_i.addr == ADDR_RECOV_MODE
      |=> recovery_half_rate_enable_o == $past(req_i.wdata[5])
  ) else $error("half-rate enable did not take written bit");

  div_decode_a: assert property (
    wr_en && req_i.addr == ADDR_RECOV_MODE && req_i.wdata[2:1] == DIV_CODE_BY2
      |=> div_sel_o == DIV_SEL_BY2
  ) else $error("division code 01 did not select divide by 2");

  eq_lane1_field_a: assert property (
    lane1_equalizer_o.boost == eq01_r[7:4] && lane0_equalizer_o.boost == eq01_r[3:0]
  ) else $error("equalizer outputs disagree with register");

  reserved_zero_a: assert property (
    rd_en && req_i.addr == ADDR_RECOV_RST |=> rvalid_o && rdata_o[7:1] == 7'h00
  ) else $error("reserved bits of recovery reset read nonzero");

  master_reserved_a: assert property (master_r[7:1] == 7'h00 && aux_r[7:2] == 6'h00)
    else $error("reserved read-only bits took a write");

endmodule

// ===== tb_serdes_rx_phy_control_regs.sv
/*
  self-checking bench for the serial receive phy control register bank.
  assumes srxp_pkg and srxp_regs are compiled first; one request per cycle.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_serdes_rx_phy_control_regs;
  import srxp_pkg::*;
  logic        mclk_i;
  logic        rst_i;
  logic        ce_i;
  srxp_req_s   req_i;
  logic [7:0]  rdata_o;
  logic        rvalid_o;
  logic        rx_all_powerdown_o;
  logic [7:0]  lane_powerdown_bits_o;
  logic [7:0]  lane_rx_powerdown_o;
  logic        sync_buffer_powerdown_o;
  logic        recovery_logic_reset_o;
  logic        recovery_half_rate_enable_o;
  srxp_div_e   div_sel_o;
  srxp_eq_s    lane0_equalizer_o;
  srxp_eq_s    lane1_equalizer_o;
  int          mismatches;
  int          n_checks;
  int          junk;
  int          sel;
  logic [11:0] a;
  logic [7:0]  exp_rd;
  logic [7:0]  m [int];
  // last two entries are unmapped on purpose
  logic [11:0] ad [8] = '{12'h200, 12'h201, 12'h203, 12'h206, 12'h230, 12'h250, 12'h202, 12'h3FF};

  srxp_regs u_srxp_regs (
    .mclk_i                      (mclk_i),
    .rst_i                       (rst_i),
    .ce_i                        (ce_i),
    .req_i                       (req_i),
    .rdata_o                     (rdata_o),
    .rvalid_o                    (rvalid_o),
    .rx_all_powerdown_o          (rx_all_powerdown_o),
    .lane_powerdown_bits_o       (lane_powerdown_bits_o),
    .lane_rx_powerdown_o         (lane_rx_powerdown_o),
    .sync_buffer_powerdown_o     (sync_buffer_powerdown_o),
    .recovery_logic_reset_o      (recovery_logic_reset_o),
    .recovery_half_rate_enable_o (recovery_half_rate_enable_o),
    .div_sel_o                   (div_sel_o),
    .lane0_equalizer_o           (lane0_equalizer_o),
    .lane1_equalizer_o           (lane1_equalizer_o)
  );

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // reserved read-only bits never take a write
  function automatic logic [7:0] wmask(input logic [11:0] ad_i);
    case (ad_i)
      12'h200, 12'h206: wmask = 8'h01;
      12'h203: wmask = 8'h03;
      default: wmask = 8'hFF;
    endcase
  endfunction

  task automatic chk_out();
    logic [3:0] e0;
    logic [3:0] e1;
    logic [2:0] dv;
    e0 = m[12'h250][3:0];
    e1 = m[12'h250][7:4];
    case (m[12'h230][2:1])
      2'h0: dv = 3'h1;
      2'h1: dv = 3'h2;
      default: dv = 3'h4;
    endcase
    `CHK("all_pd", m[12'h200][0], rx_all_powerdown_o)
    `CHK("lane_rx_pd", {8{m[12'h200][0]}} | m[12'h201], lane_rx_powerdown_o)
    `CHK("lane_bits", m[12'h201], lane_powerdown_bits_o)
    `CHK("sync_pd", m[12'h203][1], sync_buffer_powerdown_o)
    `CHK("recov_rst", m[12'h206][0], recovery_logic_reset_o)
    `CHK("half_rate", m[12'h230][5], recovery_half_rate_enable_o)
    `CHK("div_sel", dv, div_sel_o)
    `CHK("eq0", {e0 == 4'h0, e0}, lane0_equalizer_o)
    `CHK("eq1", {e1 == 4'h0, e1}, lane1_equalizer_o)
  endtask

  // request stays up for the caller's next access; idle() drops it
  task automatic acc(input logic w, input logic r, input logic [11:0] ad_i, input logic [7:0] d);
    logic       tk;
    logic [7:0] rv;
    req_i = '{wr: w, rd: r, addr: ad_i, wdata: d};
    tk = ce_i;
    rv = m.exists(ad_i) ? m[ad_i] : 8'h00;
    @(posedge mclk_i);
    #1;
    if (tk && r) exp_rd = rv;
    if (tk && w && m.exists(ad_i)) m[ad_i] = (m[ad_i] & ~wmask(ad_i)) | (d & wmask(ad_i));
    `CHK("rvalid", tk && r, rvalid_o)
    `CHK("rdata", exp_rd, rdata_o)
    chk_out();
  endtask

  task automatic idle();
    req_i = '0;
    @(posedge mclk_i);
    #1;
  endtask

  task automatic do_reset();
    req_i = '0;
    rst_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    m.delete();
    m[12'h200] = 8'h01;
    m[12'h201] = 8'h00;
    m[12'h203] = 8'h00;
    m[12'h206] = 8'h01;
    m[12'h230] = 8'h28;
    m[12'h250] = 8'h88;
    exp_rd = 8'h00;
    `CHK("rvalid_rst", 1'b0, rvalid_o)
    `CHK("rdata_rst", 8'h00, rdata_o)
    chk_out();
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end

  initial begin
    ce_i = 1'b1;
    mismatches = 0;
    n_checks = 0;
    junk = $urandom(32'h2f2a);
    do_reset();
    foreach (ad[i]) acc(1'b0, 1'b1, ad[i], 8'h00);
    $display("test reset_values done");
    for (int p = 0; p < 2; p++) begin
      foreach (ad[i]) begin
        acc(1'b1, 1'b1, ad[i], p ? 8'h00 : 8'hFF);
        acc(1'b0, 1'b1, ad[i], 8'h00);
      end
    end
    $display("test rw_patterns done");
    // half rate only with no division: divided codes mean rates of 3 Gbps or less
    for (int c = 0; c < 4; c++) acc(1'b1, 1'b0, 12'h230, {2'h0, c == 0, 2'h1, c[1:0], 1'b0});
    for (int n = 0; n < 16; n++) acc(1'b1, 1'b1, 12'h250, {n[3:0], ~n[3:0]});
    $display("test field_decode done");
    repeat (300) begin
      sel = $urandom_range(8, 0);
      a = (sel == 8) ? 12'($urandom) : ad[sel[2:0]];
      acc(1'($urandom), 1'($urandom), a, 8'($urandom));
    end
    $display("test random_access done");
    idle();
    ce_i = 1'b0;
    acc(1'b1, 1'b1, 12'h201, 8'hA5);
    ce_i = 1'b1;
    acc(1'b0, 1'b1, 12'h201, 8'h00);
    $display("test clock_enable done");
    do_reset();
    $display("test mid_reset done");
    finish_test();
  end
endmodule
